// >>> hdl/scg_pkg.sv
// Shared constants, register map and types of the system clock gear controller.
package scg_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [15:0] IDX_OSC   = 16'h10e0;
    localparam logic [15:0] IDX_GEAR  = 16'h10e1;
    localparam logic [15:0] IDX_WUP   = 16'h10e2;
    localparam logic [15:0] IDX_NOISE = 16'h10e3;
    localparam logic [15:0] IDX_KEY1  = 16'h10e4;
    localparam logic [15:0] IDX_KEY2  = 16'h10e5;
    localparam logic [15:0] IDX_DSEL  = 16'h10e8;
    localparam logic [15:0] IDX_DEN   = 16'h10e9;

    // Bit positions.
    localparam int B_HOSC   = 7;
    localparam int B_LOSC   = 6;
    localparam int B_WARM   = 2;
    localparam int B_SLOW   = 3;
    localparam int B_WUP_HI = 5;
    localparam int B_WUP_LO = 4;
    localparam int B_HLT_HI = 3;
    localparam int B_HLT_LO = 2;
    localparam int B_DRVE   = 0;
    localparam int B_PROT   = 7;
    localparam int B_EXTCLK = 2;
    localparam int B_ONE    = 1;
    localparam int B_DRVL   = 0;
    localparam int B_SRC    = 6;
    localparam int B_LOCK   = 5;
    localparam int B_DON    = 7;

    // Reset values.
    localparam logic [2:0] RST_GEAR = 3'h4;
    localparam logic [1:0] RST_WUP  = 2'h2;
    localparam logic [1:0] RST_HALT = 2'h3;

    // Protection keys.
    localparam logic [7:0] KEY_A = 8'h5a;
    localparam logic [7:0] KEY_B = 8'ha5;

    // Counter width, and counter lengths as powers of two of oscillator cycles.
    localparam int         CNT_W    = 17;
    localparam logic [4:0] EXP_SHRT = 5'h08;
    localparam logic [4:0] EXP_MID  = 5'h0e;
    localparam logic [4:0] EXP_LONG = 5'h10;
    localparam logic [4:0] EXP_LOCK = 5'h10;

    typedef enum logic [3:0] {
        KEY_IDLE = 4'h1,
        KEY_K1   = 4'h2,
        KEY_K2   = 4'h4,
        KEY_K3   = 4'h8
    } scg_key_t;

    function automatic logic [15:0] idx2adr(input logic [15:0] idx);
        return {idx[13:0], 2'b00};
    endfunction

    // Last divider count for each gear; reserved codes divide by 16.
    function automatic logic [3:0] gear_last(input logic [2:0] g);
        case (g)
            3'h0:    return 4'h0;
            3'h1:    return 4'h1;
            3'h2:    return 4'h3;
            3'h3:    return 4'h7;
            default: return 4'hf;
        endcase
    endfunction

    // Reserved code 00 is treated like the shortest warm-up.
    function automatic logic [4:0] wup_exp(input logic [1:0] s);
        case (s)
            2'h2:    return EXP_MID;
            2'h3:    return EXP_LONG;
            default: return EXP_SHRT;
        endcase
    endfunction

endpackage

// >>> hdl/scg_cnt_if.sv
// Control and status bundle between the controller and an oscillator cycle counter.
`timescale 1ns/10ps
`default_nettype none
interface scg_cnt_if;
    logic       start;
    logic       clear;
    logic       tick;
    logic [4:0] exp;
    logic       busy;
    logic       done;
    modport ctl (output start, output clear, output tick, output exp, input busy, input done);
    modport cnt (input start, input clear, input tick, input exp, output busy, output done);
endinterface
`default_nettype wire

// >>> hdl/scg_osc_counter.sv
// Binary counter of oscillator ticks used for warm-up and lock-up timing.
`timescale 1ns/10ps
`default_nettype none
module scg_osc_counter
    import scg_pkg::*;
(
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    scg_cnt_if.cnt     c
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             busy;
        logic             done;
    } scg_cnt_st_t;

    scg_cnt_st_t            st_reg;
    scg_cnt_st_t            st_next;
    logic       [CNT_W-1:0] limit;

    assign limit = {{(CNT_W-1){1'b0}}, 1'b1} << c.exp;

    always_comb begin
        st_next = st_reg;
        if (c.clear) begin
            st_next = '0;
        end else if (c.start) begin
            st_next.cnt  = '0;
            st_next.busy = 1'b1;
            st_next.done = 1'b0;
        end else if (st_reg.busy && c.tick) begin
            st_next.cnt = st_reg.cnt + 1'b1;
            if (st_next.cnt == limit) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign c.busy = st_reg.busy;
    assign c.done = st_reg.done;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // R13 restart clears count
    a_cnt_restart_zero: assert property (c.start && !c.clear |=> st_reg.busy && st_reg.cnt == '0) // R13
        else $error("counter did not restart from zero");
    // R1 exact count length
    a_cnt_done_len: assert property ($rose(st_reg.done) |-> st_reg.cnt == limit) // R1
        else $error("counter finished at wrong count");
    // R7 no early finish
    a_cnt_no_early: assert property (st_reg.busy && !c.start && !c.clear && c.tick
        && (st_reg.cnt + 1'b1) != limit |=> st_reg.busy) // R7
        else $error("counter stopped before its length");
    c_cnt_finish: cover property ($rose(st_reg.done));

endmodule // scg_osc_counter
`default_nettype wire

// >>> hdl/scg_clock_ctrl.sv
// System clock gear, doubler and register protection controller with a Wishbone slave.
`timescale 1ns/10ps
`default_nettype none
// How it works
// R1: Warm-up counts 2^8, 2^14 or 2^16 cycles of the oscillator being started.
// R2: Gear field divides the source clock by 1, 2, 4, 8 or 16.
// R3: A new gear takes effect only after the warm-up has elapsed.
// R4: Software adds a dummy write cycle when following code needs the new gear.
// R5: The doubler output runs at four times the high-frequency oscillator.
// R6: Reset leaves the doubler stopped and deselected.
// R7: Lock-up is timed by a 16-stage counter of oscillator cycles.
// R8: Lock done flag reads 1 after lock-up; software polls it first.
// R9: Doubler control writes only act while running from the high-frequency clock.
// R10: Software deselects the doubler before switching it off.
// R11: Software stops the doubler before stopping the high-frequency oscillator.
// R12: Software starts oscillator, warms up, selects it, locks doubler, then selects it.
// R13: Writing 1 to the warm-up bit clears and starts the timer; reads busy.
// R14: Software moves to the slow clock in the documented order.
// R15: Software leaves doubler operation before halting with oscillator stopped.
// R16: Low oscillator drive bit resets to 1; writing 0 weakens the drive.
// R17: External clock bit disables the oscillator and forces its second pin high.
// R18: With protection on, writes to protected registers leave them unchanged.
// R19: A blocked write raises the protection violation interrupt.
// R20: The double key sequence toggles protection.
// R21: Protection clears on reset and reads back in the noise control register.
// R22: Warm-up bit ignores a written 0, reads 1 while running, 0 when done.
// R23: Core source select picks oscillator at 0, doubler at 1, resets 0.
// R24: Only back-to-back key writes count; anything else restarts detection; the code restarts only on another write, reads leave it.
// R25: Clock source and gear switches happen only at divider boundaries.
module scg_clock_ctrl
    import scg_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [15:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        high_osc_clk_i,
    input  wire logic        low_osc_clk_i,
    output logic             high_osc_run_o,
    output logic             low_osc_run_o,
    output logic             low_osc_drive_strength_o,
    output logic             external_clock_input_o,
    output logic             high_osc_pin2_high_o,
    output logic             stop_mode_drive_o,
    output logic      [1:0]  halt_kind_select_o,
    output logic             doubler_on_o,
    output logic             lock_done_flag_o,
    output logic             core_source_select_o,
    output logic             low_freq_clock_select_o,
    output logic      [2:0]  gear_divider_select_o,
    output logic             pre_divided_clock_en_o,
    output logic             lock_violation_interrupt_o
);
    typedef struct packed {
        logic       ack;
        logic [7:0] rdata;
        logic       hosc;
        logic       losc;
        logic       slow_req;
        logic [2:0] gear_req;
        logic [1:0] wup_sel;
        logic [1:0] halt_sel;
        logic       drve;
        logic       protect;
        logic       ext_clk;
        logic       drvl;
        logic       src_req;
        logic       don;
        scg_key_t   key;
        logic       viol;
        logic [2:0] gear_cur;
        logic       slow_cur;
        logic       src_cur;
        logic [3:0] div;
        logic       pdiv_en;
        logic [2:0] hs;
        logic [2:0] ls;
        logic       hlev;
        logic       llev;
    } scg_st_t;

    scg_st_t    st_reg;
    scg_st_t    st_next;
    logic       acc;
    logic       wr;
    logic [7:0] d;
    logic       hit_prot;
    logic       wr_ok;
    logic       h_rise;
    logic       l_rise;
    logic       at_wrap;

    scg_cnt_if wup_if();
    scg_cnt_if lck_if();

    scg_osc_counter u_wup (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .c     (wup_if)
    );

    scg_osc_counter u_lck (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .c     (lck_if)
    );

    assign acc = wb_cyc_i && wb_stb_i && !st_reg.ack;
    // A write lands at the edge where the master sees ack, so both sides agree on its timing.
    assign wr  = wb_cyc_i && wb_stb_i && st_reg.ack && wb_we_i && wb_sel_i[0];
    assign d   = wb_dat_i[7:0];

    assign hit_prot = wb_adr_i == idx2adr(IDX_OSC) || wb_adr_i == idx2adr(IDX_GEAR)
                   || wb_adr_i == idx2adr(IDX_WUP) || wb_adr_i == idx2adr(IDX_NOISE)
                   || wb_adr_i == idx2adr(IDX_DSEL) || wb_adr_i == idx2adr(IDX_DEN);
    // R18 protected writes blocked
    assign wr_ok = wr && !st_reg.protect;

    // The second and third stages must agree before a level counts, filtering pin noise.
    assign h_rise = st_reg.hs[1] && st_reg.hs[2] && !st_reg.hlev;
    assign l_rise = st_reg.ls[1] && st_reg.ls[2] && !st_reg.llev;

    // R13 warm-up start
    assign wup_if.start = wr_ok && ((wb_adr_i == idx2adr(IDX_OSC) && d[B_WARM])
                                 || wb_adr_i == idx2adr(IDX_GEAR));
    assign wup_if.clear = 1'b0;
    // R1 warm-up length
    assign wup_if.exp   = wup_exp(st_reg.wup_sel);
    // The oscillator being started is the one not currently feeding the system clock.
    assign wup_if.tick  = st_reg.slow_cur ? h_rise : l_rise;

    // R7 lock-up counter
    assign lck_if.start = wr_ok && !st_reg.slow_cur && wb_adr_i == idx2adr(IDX_DEN)
                       && d[B_DON] && !st_reg.don;
    // Clearing on the next enable lets a turn-on start counting and a turn-off drop the flag.
    assign lck_if.clear = !st_next.don;
    assign lck_if.exp   = EXP_LOCK;
    assign lck_if.tick  = h_rise;

    assign at_wrap = st_reg.div == gear_last(st_reg.gear_cur);

    always_comb begin
        st_next         = st_reg;
        st_next.ack     = acc;
        st_next.viol    = 1'b0;
        st_next.pdiv_en = 1'b0;
        st_next.hs      = {st_reg.hs[1:0], high_osc_clk_i};
        st_next.ls      = {st_reg.ls[1:0], low_osc_clk_i};
        if (st_reg.hs[1] == st_reg.hs[2]) begin
            st_next.hlev = st_reg.hs[2];
        end
        if (st_reg.ls[1] == st_reg.ls[2]) begin
            st_next.llev = st_reg.ls[2];
        end

        if (acc) begin
            st_next.rdata = 8'h00;
            case (wb_adr_i)
                idx2adr(IDX_OSC): begin
                    st_next.rdata[B_HOSC] = st_reg.hosc;
                    st_next.rdata[B_LOSC] = st_reg.losc;
                    // R22 busy readback
                    st_next.rdata[B_WARM] = wup_if.busy;
                end
                idx2adr(IDX_GEAR): begin
                    st_next.rdata[B_SLOW] = st_reg.slow_req;
                    st_next.rdata[2:0]     = st_reg.gear_req;
                end
                idx2adr(IDX_WUP): begin
                    st_next.rdata[B_WUP_HI:B_WUP_LO] = st_reg.wup_sel;
                    st_next.rdata[B_HLT_HI:B_HLT_LO] = st_reg.halt_sel;
                    st_next.rdata[B_DRVE]            = st_reg.drve;
                end
                idx2adr(IDX_NOISE): begin
                    // R21 protect flag readback
                    st_next.rdata[B_PROT]  = st_reg.protect;
                    st_next.rdata[B_EXTCLK] = st_reg.ext_clk;
                    st_next.rdata[B_ONE]   = 1'b1;
                    st_next.rdata[B_DRVL]  = st_reg.drvl;
                end
                idx2adr(IDX_DSEL): begin
                    st_next.rdata[B_SRC]   = st_reg.src_req;
                    // R8 lock status
                    st_next.rdata[B_LOCK]  = lck_if.done;
                end
                idx2adr(IDX_DEN): begin
                    st_next.rdata[B_DON] = st_reg.don;
                end
                default: begin
                    st_next.rdata = 8'h00;
                end
            endcase
        end

        // R19 violation pulse
        if (wr && hit_prot && st_reg.protect) begin
            st_next.viol = 1'b1;
        end

        if (wr_ok) begin
            case (wb_adr_i)
                idx2adr(IDX_OSC): begin
                    st_next.hosc = d[B_HOSC];
                    st_next.losc = d[B_LOSC];
                end
                idx2adr(IDX_GEAR): begin
                    st_next.slow_req  = d[B_SLOW];
                    st_next.gear_req  = d[2:0];
                end
                idx2adr(IDX_WUP): begin
                    st_next.wup_sel  = d[B_WUP_HI:B_WUP_LO];
                    st_next.halt_sel = d[B_HLT_HI:B_HLT_LO];
                    st_next.drve     = d[B_DRVE];
                end
                idx2adr(IDX_NOISE): begin
                    // R16 drive strength bit
                    st_next.drvl  = d[B_DRVL];
                    // R17 external clock bit
                    st_next.ext_clk = d[B_EXTCLK];
                end
                idx2adr(IDX_DSEL): begin
                    // R9 ignored while slow
                    if (!st_reg.slow_cur) begin
                        st_next.src_req = d[B_SRC];
                    end
                end
                idx2adr(IDX_DEN): begin
                    if (!st_reg.slow_cur) begin
                        st_next.don = d[B_DON];
                    end
                end
                default: begin
                    st_next.don = st_reg.don;
                end
            endcase
        end

        // R24 key detector
        if (wr) begin
            st_next.key = KEY_IDLE;
            if (wb_adr_i == idx2adr(IDX_KEY1) && d == KEY_A) begin
                st_next.key = KEY_K1;
            end
            unique case (st_reg.key)
                KEY_IDLE: begin
                end
                KEY_K1: begin
                    if (wb_adr_i == idx2adr(IDX_KEY2) && d == KEY_B) begin
                        st_next.key = KEY_K2;
                    end
                end
                KEY_K2: begin
                    if (wb_adr_i == idx2adr(IDX_KEY1) && d == KEY_B) begin
                        st_next.key = KEY_K3;
                    end
                end
                KEY_K3: begin
                    // R20 toggle on second key
                    if (wb_adr_i == idx2adr(IDX_KEY2) && d == KEY_A) begin
                        st_next.protect = !st_reg.protect;
                    end
                end
                default: begin
                    st_next.key = KEY_IDLE;
                end
            endcase
        end

        // R25 switch at boundary
        if (at_wrap) begin
            st_next.div     = 4'h0;
            st_next.pdiv_en = 1'b1;
            // R23 core source select
            st_next.src_cur = st_reg.src_req;
            // R3 wait for warm-up
            if (!wup_if.busy) begin
                st_next.gear_cur  = st_reg.gear_req;
                st_next.slow_cur  = st_reg.slow_req;
            end
        end else begin
            // R2 gear divider
            st_next.div = st_reg.div + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg           <= '0;
            st_reg.hosc      <= 1'b1;
            st_reg.gear_req  <= RST_GEAR;
            st_reg.gear_cur  <= RST_GEAR;
            st_reg.wup_sel   <= RST_WUP;
            st_reg.halt_sel  <= RST_HALT;
            st_reg.drvl      <= 1'b1;
            st_reg.key       <= KEY_IDLE;
            // R6 doubler stopped
            st_reg.don       <= 1'b0;
            st_reg.src_req   <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign wb_dat_o                   = {24'h000000, st_reg.rdata};
    assign wb_ack_o                   = st_reg.ack;
    assign high_osc_run_o             = st_reg.hosc && !st_reg.ext_clk;
    assign low_osc_run_o              = st_reg.losc;
    assign low_osc_drive_strength_o   = st_reg.drvl;
    assign external_clock_input_o     = st_reg.ext_clk;
    assign high_osc_pin2_high_o       = st_reg.ext_clk;
    assign stop_mode_drive_o          = st_reg.drve;
    assign halt_kind_select_o         = st_reg.halt_sel;
    // R5 enables the times-four multiplier
    assign doubler_on_o               = st_reg.don;
    assign lock_done_flag_o           = lck_if.done;
    assign core_source_select_o       = st_reg.src_cur;
    assign low_freq_clock_select_o    = st_reg.slow_cur;
    assign gear_divider_select_o      = st_reg.gear_cur;
    assign pre_divided_clock_en_o     = st_reg.pdiv_en;
    assign lock_violation_interrupt_o = st_reg.viol;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_reset_defaults: assert property ($past(rst_i) |-> !doubler_on_o && !st_reg.protect
        && !core_source_select_o && low_osc_drive_strength_o && !external_clock_input_o) // R6
        else $error("reset values wrong");
    a_gear_after_warm: assert property ($changed(gear_divider_select_o)
        |-> $past(!wup_if.busy && at_wrap)) // R3
        else $error("gear changed during warm-up");
    a_source_at_wrap: assert property ($changed(core_source_select_o) |-> $past(at_wrap)) // R25
        else $error("source switched off a boundary");
    a_gear_div_one: assert property (gear_divider_select_o == 3'h0
        && $past(gear_divider_select_o) == 3'h0 |-> pre_divided_clock_en_o) // R2
        else $error("divide by one missed a pulse");
    a_protect_blocks: assert property (wr && st_reg.protect && wb_adr_i == idx2adr(IDX_OSC)
        |=> $stable(high_osc_run_o) && $stable(low_osc_run_o)) // R18
        else $error("protected register changed");
    a_violation_irq: assert property (wr && hit_prot && st_reg.protect
        |=> lock_violation_interrupt_o ##1 !lock_violation_interrupt_o) // R19
        else $error("violation pulse wrong");
    a_key_toggle: assert property (wr && st_reg.key == KEY_K3 && wb_adr_i == idx2adr(IDX_KEY2)
        && d == KEY_A |=> st_reg.protect != $past(st_reg.protect)) // R20
        else $error("second key did not toggle protection");
    a_key_bad_hold: assert property (wr && st_reg.key != KEY_K3 |=> $stable(st_reg.protect)) // R24
        else $error("protection changed without full key");
    a_warm_flag: assert property (wr_ok && wb_adr_i == idx2adr(IDX_OSC) && d[B_WARM]
        |=> wup_if.busy) // R22
        else $error("warm-up did not start");
    a_lock_needs_on: assert property (lock_done_flag_o |-> doubler_on_o) // R8
        else $error("lock flag set with doubler off");

    c_key_toggle: cover property ($changed(st_reg.protect));
    c_lock_done: cover property ($rose(lock_done_flag_o));
    c_gear_switch: cover property ($changed(gear_divider_select_o));
    c_violation: cover property (lock_violation_interrupt_o);

endmodule // scg_clock_ctrl
`default_nettype wire

// >>> verif/scg_clock_ctrl_test.sv
// Self-checking register-level testbench of the system clock gear controller.
`timescale 1ns/10ps
`default_nettype none
module scg_clock_ctrl_test
    import scg_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [15:0] wb_adr_i = 16'h0;
    logic [3:0]  wb_sel_i = 4'h1;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic        wb_ack_o, hosc = 1'b0, losc = 1'b0, hrun, lrun, drv, ext, pin2, sdrv, don;
    logic        lock, csel, slow, pden, viol;
    logic [1:0]  hk;
    logic [2:0]  gear;
    logic [7:0]  rd;
    int          n_mismatch = 0, n_tests = 0, n_viol = 0, k, g;

    scg_clock_ctrl i_scg_clock_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .high_osc_clk_i(hosc),
        .low_osc_clk_i(losc), .high_osc_run_o(hrun), .low_osc_run_o(lrun),
        .low_osc_drive_strength_o(drv), .external_clock_input_o(ext),
        .high_osc_pin2_high_o(pin2), .stop_mode_drive_o(sdrv), .halt_kind_select_o(hk),
        .doubler_on_o(don), .lock_done_flag_o(lock), .core_source_select_o(csel),
        .low_freq_clock_select_o(slow), .gear_divider_select_o(gear),
        .pre_divided_clock_en_o(pden), .lock_violation_interrupt_o(viol));

    always #2 clk_i = ~clk_i;

    // Oscillator pins toggle every two clocks, the fastest the synchronisers accept.
    always begin
        repeat (2) @(posedge clk_i);
        hosc <= ~hosc;
        losc <= ~losc;
    end

    always @(posedge clk_i) begin
        if (viol === 1'b1) n_viol++;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bus(input logic we, input logic [15:0] idx, input logic [7:0] wd);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx[13:0], 2'b00};
        wb_dat_i <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            wrap_up();
        end
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rchk(input string name, input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(name, exp, rd);
    endtask

    // Polls the warm-up bit; about 256 low pin edges keep the count far above the lower bound.
    task automatic wup_wait();
        k = 0;
        do begin
            bus(1'b0, IDX_OSC, 8'h00);
            k++;
        end while (rd[2] !== 1'b0 && k < 2000);
        chk("wup long", 8'h01, (k > 100 && k < 2000) ? 8'h01 : 8'h00);
        if (k >= 2000) wrap_up();
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rchk("osc", IDX_OSC, 8'h80);
        rchk("gear", IDX_GEAR, 8'h04);
        rchk("wup", IDX_WUP, 8'h2c);
        rchk("noise", IDX_NOISE, 8'h03);
        rchk("dsel", IDX_DSEL, 8'h00);
        rchk("den", IDX_DEN, 8'h00);
        rchk("key", IDX_KEY1, 8'h00);
        rchk("unmapped", 16'h10f0, 8'h00);
        chk("pins", 8'h98, {hrun, lrun, sdrv, hk, csel, slow, 1'b0});
        $display("test reset done");
        // Shortest warm-up keeps each gear change near a thousand clocks.
        bus(1'b1, IDX_WUP, 8'h1c);
        for (g = 0; g < 5; g++) begin
            bus(1'b1, IDX_GEAR, g[7:0]);
            chk("gear held", (g == 0) ? 8'h04 : 8'(g - 1), {5'h0, gear});
            rchk("busy", IDX_OSC, 8'h84);
            wup_wait();
            k = 0;
            while (gear !== g[2:0] && k < 40) begin
                @(posedge clk_i);
                k++;
            end
            chk("gear applied", g[7:0], {5'h0, gear});
            k = 0;
            repeat (32) begin
                @(posedge clk_i);
                if (pden === 1'b1) k++;
            end
            chk("pulses", 8'(32 >> g), k[7:0]);
        end
        $display("test gear done");
        bus(1'b1, IDX_NOISE, 8'h06);
        repeat (2) @(posedge clk_i);
        chk("ext", 8'h31, {1'b0, hrun, ext, pin2, 2'h0, drv, 1'b1});
        bus(1'b1, IDX_NOISE, 8'h03);
        bus(1'b1, IDX_DEN, 8'h80);
        repeat (2) @(posedge clk_i);
        chk("doubler", 8'h02, {6'h0, don, lock});
        rchk("lock", IDX_DSEL, 8'h00);
        bus(1'b1, IDX_DSEL, 8'h00);
        bus(1'b1, IDX_DEN, 8'h00);
        chk("doubler off", 8'h00, {6'h0, don, lock});
        $display("test noise doubler done");
        // Broken key order must leave protection off.
        bus(1'b1, IDX_KEY1, KEY_A);
        bus(1'b1, IDX_KEY2, KEY_B);
        bus(1'b1, IDX_KEY1, KEY_B);
        bus(1'b1, IDX_KEY1, KEY_A);
        rchk("prot off", IDX_NOISE, 8'h03);
        bus(1'b1, IDX_KEY2, KEY_B);
        bus(1'b1, IDX_KEY1, KEY_B);
        bus(1'b1, IDX_KEY2, KEY_A);
        rchk("prot on", IDX_NOISE, 8'h83);
        bus(1'b1, IDX_GEAR, 8'h02);
        rchk("blocked", IDX_GEAR, 8'h04);
        chk("viol", 8'h01, n_viol[7:0]);
        bus(1'b1, IDX_OSC, 8'h44);
        rchk("osc blocked", IDX_OSC, 8'h80);
        bus(1'b1, IDX_KEY1, KEY_A);
        bus(1'b1, IDX_KEY2, KEY_B);
        bus(1'b1, IDX_KEY1, KEY_B);
        bus(1'b1, IDX_KEY2, KEY_A);
        rchk("prot off", IDX_NOISE, 8'h03);
        bus(1'b1, IDX_WUP, 8'h15);
        rchk("wup open", IDX_WUP, 8'h15);
        chk("halt pins", 8'h05, {5'h0, sdrv, hk});
        chk("viol", 8'h02, n_viol[7:0]);
        $display("test protection done");
        // Move to the slow clock in the required order, then stop the fast oscillator.
        bus(1'b1, IDX_OSC, 8'hc4);
        rchk("wup bit", IDX_OSC, 8'hc4);
        wup_wait();
        bus(1'b1, IDX_GEAR, 8'h0c);
        wup_wait();
        repeat (20) @(posedge clk_i);
        bus(1'b1, IDX_OSC, 8'h40);
        chk("slow", 8'h03, {5'h0, hrun, lrun, slow});
        $display("test slow clock done");
        wrap_up();
    end
endmodule // scg_clock_ctrl_test
`default_nettype wire
